/* File: hm_alert_defines.vh */
`ifndef HM_ALERT_DEFINES_VH
`define HM_ALERT_DEFINES_VH
`define TEMP_W          8
`define HYST_COMPARATOR 8'h7f
`define CFG_SHUT_EN_BIT 2
`define MODE_SHUTDOWN   2'h0
`define MODE_COMPARATOR 2'h1
`define MODE_TWO_TIMES  2'h2
`define MODE_ONE_TIME   2'h3
`endif

/* File: temp_channel_irq.v */
`timescale 1ns/1ps
`include "hm_alert_defines.vh"
module temp_channel_irq #(
  parameter W = 8
) (
  // clock and reset
  input  wire         clk,
  input  wire         sys_rst,
  // mode and limits
  input  wire [1:0]   mode,
  input  wire [W-1:0] temp,
  input  wire [W-1:0] over_thr,
  input  wire [W-1:0] hyst_thr,
  input  wire [W-1:0] shut_high,
  input  wire [W-1:0] shut_low,
  // events
  output reg          evt,
  output reg          urgent_evt
);
  reg  above_reg;
  reg  armed_reg;
  reg  shut_hi_reg;
  reg  shut_lo_reg;
  reg  shut_first_reg;
  wire above_now = $signed(temp) > $signed(over_thr);
  wire below_hyst = $signed(temp) < $signed(hyst_thr);
  wire hi_now = $signed(temp) > $signed(shut_high);
  wire lo_now = $signed(temp) < $signed(shut_low);
  wire cmp_now = $signed(temp) > $signed(over_thr);

  always @* begin
    evt = 1'b0;
    urgent_evt = 1'b0;
    case (mode)
      `MODE_SHUTDOWN: begin
        // later rises above the high limit are ordinary events, only the first one jumps the queue
        evt = (above_now && armed_reg) || (below_hyst && !armed_reg) || (lo_now && !shut_lo_reg)
              || (hi_now && !shut_hi_reg && !shut_first_reg);
        urgent_evt = hi_now && !shut_hi_reg && shut_first_reg;
      end
      `MODE_COMPARATOR: begin
        // level request: re-fires after every clearing read while hot
        evt = cmp_now || (above_reg && !below_hyst);
      end
      `MODE_TWO_TIMES: begin
        evt = (above_now && armed_reg) || (below_hyst && !armed_reg);
      end
      `MODE_ONE_TIME: begin
        evt = above_now && armed_reg;
      end
      default: begin
        evt = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      above_reg <= 1'b0;
      armed_reg <= 1'b1;
      shut_hi_reg <= 1'b0;
      shut_lo_reg <= 1'b0;
      shut_first_reg <= 1'b1;
    end else begin
      shut_hi_reg <= hi_now;
      shut_lo_reg <= lo_now;
      if (urgent_evt)
        shut_first_reg <= 1'b0;
      if (above_now)
        above_reg <= 1'b1;
      else if (below_hyst)
        above_reg <= 1'b0;
      // rise suppressed until the temperature has gone below hysteresis
      if (above_now && armed_reg)
        armed_reg <= 1'b0;
      else if (below_hyst)
        armed_reg <= 1'b1;
    end
  end
endmodule

/* File: hw_monitor_alert_interrupt.v */
`timescale 1ns/1ps
`include "hm_alert_defines.vh"
module hw_monitor_alert_interrupt #(
  parameter NV = 8,
  parameter NF = 3,
  parameter NT = 6,
  parameter W  = 8,
  parameter FW = 8
) (
  // clock and reset
  input  wire              clk,
  input  wire              sys_rst,
  // configuration
  input  wire              monitor_alert_mode,
  input  wire [NT-1:0]     shutdown_behaviour_enable,
  input  wire              channel1_single_shot,
  input  wire              group_comparator_select,
  input  wire [NT-1:0]     channel_irq_mask,
  input  wire [NV-1:0]     volt_irq_mask,
  input  wire [NF-1:0]     fan_irq_mask,
  // voltage compare results from the measurement front end
  input  wire [NV-1:0]     volt_above_high,
  input  wire [NV-1:0]     volt_below_low,
  // fan counts and limits
  input  wire [NF*FW-1:0]  fan_count,
  input  wire [NF*FW-1:0]  fan_limit,
  // temperature channels
  input  wire [NT*W-1:0]   temp_value,
  input  wire [NT*W-1:0]   over_threshold,
  input  wire [NT*W-1:0]   hysteresis_threshold,
  input  wire [NT*W-1:0]   shutdown_over_limit,
  input  wire [NT*W-1:0]   shutdown_high_limit,
  input  wire [NT*W-1:0]   shutdown_low_limit,
  // overtemp level from the separate overtemp logic
  input  wire              overtemp_level,
  // status read: pulse when software has read every status register
  input  wire              status_read_done,
  // status
  output reg  [NV-1:0]     volt_status,
  output reg  [NF-1:0]     fan_status,
  output reg  [NT-1:0]     temp_status,
  output wire              irq_pending,
  // shared alert pin, open drain
  output wire              mgmt_alert_pin_out,
  output wire              mgmt_alert_pin_oe
);
  reg  [NF-1:0] fan_above_reg;
  reg  [NF-1:0] fan_seen_reg;
  reg           pending_reg;
  wire [NT-1:0] t_evt;
  wire [NT-1:0] t_urgent;
  wire [NF-1:0] fan_above_now;
  wire [NF-1:0] fan_cross;
  wire [NV-1:0] volt_evt;

  assign volt_evt = (volt_above_high | volt_below_low) & ~volt_irq_mask;

  genvar i;
  generate
    for (i = 0; i < NF; i = i + 1) begin : g_fan
      assign fan_above_now[i] = fan_count[i*FW +: FW] > fan_limit[i*FW +: FW];
      // first sample after reset only seeds the previous state
      assign fan_cross[i] = fan_seen_reg[i] && (fan_above_now[i] != fan_above_reg[i]) && !fan_irq_mask[i];
    end
    for (i = 0; i < NT; i = i + 1) begin : g_temp
      reg  [1:0]   mode_sel;
      wire [W-1:0] hy = hysteresis_threshold[i*W +: W];
      wire [W-1:0] ol = shutdown_over_limit[i*W +: W];
      wire [W-1:0] ov = over_threshold[i*W +: W];
      always @* begin
        if (i == 0) begin
          if (hy == `HYST_COMPARATOR)
            mode_sel = `MODE_COMPARATOR;
          else if (($signed(hy) < $signed(ol)) && shutdown_behaviour_enable[i])
            mode_sel = `MODE_SHUTDOWN;
          else if (channel1_single_shot)
            mode_sel = `MODE_ONE_TIME;
          else
            mode_sel = `MODE_TWO_TIMES;
        end else begin
          if (group_comparator_select)
            mode_sel = `MODE_COMPARATOR;
          else if (shutdown_behaviour_enable[i])
            mode_sel = `MODE_SHUTDOWN;
          else
            mode_sel = `MODE_TWO_TIMES;
        end
      end
      temp_channel_irq #(
        .W(W)
      ) u_ch (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .mode       (mode_sel),
        .temp       (temp_value[i*W +: W]),
        .over_thr   ((mode_sel == `MODE_SHUTDOWN) ? ol : ov),
        .hyst_thr   (hy),
        .shut_high  (shutdown_high_limit[i*W +: W]),
        .shut_low   (shutdown_low_limit[i*W +: W]),
        .evt        (t_evt[i]),
        .urgent_evt (t_urgent[i])
      );
    end
  endgenerate

  wire [NT-1:0] t_ok  = ~channel_irq_mask;
  wire          any_evt = (|volt_evt) | (|fan_cross) | (|(t_evt & t_ok));
  wire [NT-1:0] urg   = t_urgent & t_ok;
  // an event in the clearing cycle is taken, so set wins over clear
  wire          take  = !pending_reg || status_read_done;

  always @(posedge clk) begin
    if (sys_rst) begin
      fan_above_reg <= {NF{1'b0}};
      fan_seen_reg  <= {NF{1'b0}};
      pending_reg   <= 1'b0;
      volt_status   <= {NV{1'b0}};
      fan_status    <= {NF{1'b0}};
      temp_status   <= {NT{1'b0}};
    end else begin
      fan_above_reg <= fan_above_now;
      fan_seen_reg  <= {NF{1'b1}};
      if (take) begin
        pending_reg <= any_evt | (|urg);
        volt_status <= volt_evt;
        fan_status  <= fan_cross;
        temp_status <= (t_evt | t_urgent) & t_ok;
      end else if (|urg) begin
        temp_status <= temp_status | urg;
      end
    end
  end

  assign irq_pending = pending_reg;
  // alert mode drives low on pending, overtemp mode shows the overtemp level
  wire   drive_low = monitor_alert_mode ? pending_reg : overtemp_level;
  assign mgmt_alert_pin_out = 1'b0;
  assign mgmt_alert_pin_oe  = drive_low;
endmodule

/* File: hm_alert_sva.sv */
`timescale 1ns/1ps
module hm_alert_sva #(
  parameter NV = 8,
  parameter NF = 3,
  parameter NT = 6
) (
  // clock and reset
  input wire          clk,
  input wire          sys_rst,
  // watched ports
  input wire          monitor_alert_mode,
  input wire          overtemp_level,
  input wire          status_read_done,
  input wire [NV-1:0] volt_above_high,
  input wire [NV-1:0] volt_below_low,
  input wire [NV-1:0] volt_irq_mask,
  input wire [NV-1:0] volt_status,
  input wire          irq_pending,
  input wire          mgmt_alert_pin_out,
  input wire          mgmt_alert_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence evt_s;
    monitor_alert_mode && !irq_pending && |((volt_above_high | volt_below_low) & ~volt_irq_mask);
  endsequence
  sequence held_s;
    irq_pending && !status_read_done;
  endsequence
  volt_pend_a: assert property (evt_s |=> irq_pending && volt_status != 0) else $error("volt event lost");
  pend_hold_a: assert property (held_s |=> irq_pending) else $error("pending dropped");
  status_keep_a: assert property (held_s |=> $stable(volt_status)) else $error("status moved");
  clear_cause_a: assert property ($fell(irq_pending) |-> $past(status_read_done)) else $error("bad clear");
  pin_level_a: assert property (mgmt_alert_pin_out == 1'b0) else $error("pin out high");
  alert_pin_a: assert property (monitor_alert_mode && $past(monitor_alert_mode)
    |-> mgmt_alert_pin_oe == irq_pending) else $error("pin not pending");
  ovt_pin_a: assert property (!monitor_alert_mode && $past(!monitor_alert_mode) && $stable(overtemp_level)
    |-> mgmt_alert_pin_oe == overtemp_level) else $error("overtemp pin");
  evt_drive_a: assert property (evt_s ##1 held_s |=> mgmt_alert_pin_oe) else $error("pin released");
endmodule
bind hw_monitor_alert_interrupt hm_alert_sva #(.NV(NV), .NF(NF), .NT(NT)) i_sva (.*);

/* File: host_status_reader.sv */
`timescale 1ns/1ps
module host_status_reader (
  // clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // request and answer delay
  input  wire       go,
  input  wire [1:0] lag,
  // to block
  output reg        status_read_done,
  output reg        busy
);
  reg [1:0] cnt_reg;
  always @(posedge clk) begin
    status_read_done <= 1'b0;
    if (sys_rst) begin
      busy <= 1'b0;
    end else if (go && !busy) begin
      busy    <= 1'b1;
      cnt_reg <= lag;
    end else if (busy && cnt_reg == 2'h0) begin
      // one pulse once every status register has been read
      status_read_done <= 1'b1;
      busy             <= 1'b0;
    end else if (busy) begin
      cnt_reg <= cnt_reg - 2'h1;
    end
  end
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  reg         clk = 0, sys_rst = 1, go = 0, overtemp_level = 0;
  reg         monitor_alert_mode = 1, channel1_single_shot = 0, group_comparator_select = 0;
  reg  [1:0]  lag = 0;
  reg  [5:0]  shutdown_behaviour_enable = 0, channel_irq_mask = 0;
  reg  [7:0]  volt_irq_mask = 0, volt_above_high = 0, volt_below_low = 0;
  reg  [2:0]  fan_irq_mask = 0;
  reg  [23:0] fan_count = {3{8'h10}}, fan_limit = {3{8'h80}};
  reg  [47:0] temp_value = {6{8'h14}}, over_threshold = {6{8'h32}}, hysteresis_threshold = {6{8'h28}};
  reg  [47:0] shutdown_over_limit = {6{8'h3c}}, shutdown_high_limit = {6{8'h50}}, shutdown_low_limit = 0;
  wire        status_read_done, busy, irq_pending, mgmt_alert_pin_out, mgmt_alert_pin_oe;
  wire [7:0]  volt_status;
  wire [2:0]  fan_status;
  wire [5:0]  temp_status;
  integer     err_total = 0, checked = 0, cyc = 0;
  hw_monitor_alert_interrupt i_dut (.*);
  host_status_reader i_host (.*);
  always #12.5 clk = ~clk;
  task tick(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task chk(input [7:0] e, input [7:0] g);
    begin
      checked = checked + 1;
      if (e !== g) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: %h vs %h", $time, e, g);
      end
    end
  endtask
  task chb(input e, input g);
    chk({7'h0, e}, {7'h0, g});
  endtask
  // the host pulses the read after 0 to 3 extra cycles
  task rd(input [1:0] l);
    begin
      lag = l;
      go = 1;
      tick(1);
      go = 0;
      while (busy) tick(1);
      tick(3);
    end
  endtask
  task print_verdict;
    begin
      if (err_total == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      print_verdict;
    end
  end
  initial begin
    tick(8);
    sys_rst = 0;
    tick(3);
    chb(0, irq_pending);
    volt_above_high = 8'h01;
    tick(1);
    volt_above_high = 0;
    tick(2);
    volt_below_low = 8'h02; // dropped while pending
    tick(1);
    volt_below_low = 0;
    tick(2);
    chk(8'h01, volt_status);
    chb(1, mgmt_alert_pin_oe);
    rd(0);
    chb(0, mgmt_alert_pin_oe);
    volt_below_low = 8'h02;
    tick(1);
    volt_below_low = 0;
    tick(2);
    chk(8'h02, volt_status);
    rd(0);
    volt_irq_mask = 8'h08;
    volt_above_high = 8'h08;
    tick(1);
    volt_above_high = 0;
    tick(3);
    chb(0, irq_pending);
    fan_count[7:0] = 8'h90;
    tick(4);
    chk(8'h01, {5'h0, fan_status});
    rd(3);
    fan_count[7:0] = 8'h10;
    tick(4);
    chb(1, irq_pending);
    rd(1);
    temp_value[7:0] = 8'h37;
    tick(4);
    chk(8'h01, {2'h0, temp_status});
    rd(0);
    chb(0, irq_pending);
    temp_value[7:0] = 8'h1e;
    tick(4);
    chb(1, irq_pending);
    rd(0);
    channel1_single_shot = 1;
    temp_value[7:0] = 8'h37;
    tick(4);
    chb(1, irq_pending);
    rd(0);
    temp_value[7:0] = 8'h1e;
    tick(4);
    chb(0, irq_pending);
    hysteresis_threshold[7:0] = 8'h7f;
    temp_value[7:0] = 8'h37;
    tick(4);
    rd(2);
    chb(1, irq_pending);
    temp_value[7:0] = 8'h14;
    rd(0);
    chb(0, irq_pending);
    group_comparator_select = 1;
    temp_value[15:8] = 8'h37;
    tick(4);
    rd(1);
    chb(1, irq_pending);
    temp_value[15:8] = 8'h2d;
    rd(0);
    chk(8'h02, {2'h0, temp_status});
    temp_value[15:8] = 8'h14;
    rd(0);
    chb(0, irq_pending);
    group_comparator_select = 0;
    hysteresis_threshold[7:0] = 8'h28;
    shutdown_behaviour_enable = 6'h03;
    temp_value[7:0] = 8'h37; // above threshold but under the shutdown limit
    tick(4);
    chb(0, irq_pending);
    temp_value[7:0] = 8'h41;
    tick(4);
    chb(1, irq_pending);
    rd(0);
    temp_value[7:0] = 8'h14;
    tick(4);
    temp_value[15:8] = 8'h55;
    tick(4);
    chk(8'h03, {2'h0, temp_status});
    rd(0);
    monitor_alert_mode = 0;
    overtemp_level = 1;
    tick(3);
    chb(1, mgmt_alert_pin_oe);
    overtemp_level = 0;
    tick(3);
    chb(0, mgmt_alert_pin_oe);
    print_verdict;
  end
endmodule
